// file: design/sdmcc_fifo.sv
`timescale 1ns/1ps
`default_nettype none

module sdmcc_fifo #(
   parameter int WIDTH = 1,
   parameter int DEPTH = 8
) (
   input wire logic ref_clk_in,
   input wire logic rstn_in,
   sdmcc_fifo_if.fifo f
);
   localparam int AW = $clog2(DEPTH);
   localparam logic [AW:0] DEPTH_C = (AW+1)'(DEPTH);
   localparam logic [AW-1:0] LAST_C = AW'(DEPTH - 1);

   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [AW-1:0] wp_q, wp_d, rp_q, rp_d;
   logic [AW:0] cnt_q, cnt_d;
   logic push, pop;

   assign f.wr_ready = (cnt_q != DEPTH_C);
   assign f.rd_valid = (cnt_q != '0);
   assign f.rd_data = mem_q[rp_q];
   assign push = f.wr_valid && f.wr_ready;
   assign pop = f.rd_valid && f.rd_ready;

   always_comb begin
      wp_d = wp_q;
      rp_d = rp_q;
      cnt_d = cnt_q;
      if (push) begin
         wp_d = (wp_q == LAST_C) ? '0 : wp_q + 1'b1;
      end
      if (pop) begin
         rp_d = (rp_q == LAST_C) ? '0 : rp_q + 1'b1;
      end
      if (push && !pop) begin
         cnt_d = cnt_q + 1'b1;
      end else if (pop && !push) begin
         cnt_d = cnt_q - 1'b1;
      end
   end

   always_ff @(posedge ref_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         wp_q <= '0;
         rp_q <= '0;
         cnt_q <= '0;
      end else begin
         wp_q <= wp_d;
         rp_q <= rp_d;
         cnt_q <= cnt_d;
      end
   end

   // Storage needs no reset; reads are guarded by the count.
   always_ff @(posedge ref_clk_in) begin
      if (push) begin
         mem_q[wp_q] <= f.wr_data;
      end
   end
endmodule // sdmcc_fifo

`default_nettype wire

// file: design/sdmcc_fifo_if.sv
`timescale 1ns/1ps
`default_nettype none

interface sdmcc_fifo_if #(
   parameter int WIDTH = 1
);
   logic wr_valid;
   logic wr_ready;
   logic [WIDTH-1:0] wr_data;
   logic rd_valid;
   logic rd_ready;
   logic [WIDTH-1:0] rd_data;

   modport fifo (
      input wr_valid,
      input wr_data,
      output wr_ready,
      output rd_valid,
      output rd_data,
      input rd_ready
   );

   modport user (
      output wr_valid,
      output wr_data,
      input wr_ready,
      input rd_valid,
      input rd_data,
      output rd_ready
   );
endinterface

`default_nettype wire

// file: design/sdmcc_pkg.sv
package sdmcc_pkg;

   // Special function register addresses.
   localparam logic [7:0] SDMCC_ADDR_CLKDIV = 8'hf7;
   localparam logic [7:0] SDMCC_ADDR_DECH = 8'h9b;
   localparam logic [7:0] SDMCC_ADDR_DECL = 8'h9a;
   localparam logic [7:0] SDMCC_ADDR_CTRL = 8'hf8;
   localparam logic [7:0] SDMCC_ADDR_OFFS = 8'hf9;
   localparam logic [7:0] SDMCC_ADDR_STAT = 8'hfa;

   // Reset values.
   localparam logic [7:0] SDMCC_RST_CLKDIV = 8'h00;
   localparam logic [2:0] SDMCC_RST_DECH = 3'h7;
   localparam logic [7:0] SDMCC_RST_DECL = 8'hff;
   localparam logic [7:0] SDMCC_RST_CTRL = 8'h00;
   localparam logic [7:0] SDMCC_RST_OFFS = 8'h00;

   // Control register fields.
   localparam int SDMCC_CTRL_GAIN_LSB = 0;
   localparam int SDMCC_CTRL_GAIN_W = 3;
   localparam int SDMCC_CTRL_EN_BIT = 3;
   localparam int SDMCC_CTRL_REFX_BIT = 4;
   localparam int SDMCC_CTRL_BUF_LSB = 5;
   localparam int SDMCC_CTRL_BUF_W = 2;

   // Status register fields.
   localparam int SDMCC_STAT_OVF_BIT = 0;
   localparam int SDMCC_STAT_RUN_BIT = 1;

   // Modulator and decimation figures.
   localparam int SDMCC_OSR = 128;
   localparam int SDMCC_DECIMATION_RATIO_W = 11;
   localparam logic [10:0] SDMCC_DECIMATION_RATIO_MIN = 11'h013;

   typedef enum logic [1:0] {
      SDMCC_BUF_BYPASS,
      SDMCC_BUF_LOW,
      SDMCC_BUF_HIGH,
      SDMCC_BUF_BYPASS2
   } sdmcc_buf_t;

endpackage

// file: design/sdmcc_top.sv
`timescale 1ns/1ps
`default_nettype none

module sdmcc_top
   import sdmcc_pkg::*;
#(
   parameter int FIFO_DEPTH = 8
) (
   input wire logic ref_clk_in,
   input wire logic rstn_in,
   input wire logic [7:0] sfr_addr_in,
   input wire logic sfr_wr_in,
   input wire logic sfr_rd_in,
   input wire logic [7:0] sfr_wdata_in,
   output logic [7:0] sfr_rdata_out,
   input wire logic mod_bit_in,
   output logic modulator_clock_out,
   output logic sample_strobe_out,
   output logic [7:0] pga_gain_sel_out,
   output logic buf_high_en_out,
   output logic buf_low_en_out,
   output logic buf_bypass_out,
   output logic ref_ext_sel_out,
   output logic [7:0] offset_dac_out,
   output logic code_valid_out,
   output logic code_bit_out,
   input wire logic code_ready_in,
   output logic word_strobe_out
);

   function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
      hit = (a == r);
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Register file.

   logic [7:0] clkdiv_q, clkdiv_d;
   logic [7:0] ctrl_q, ctrl_d;
   logic [7:0] offs_q, offs_d;
   logic [2:0] dech_q, dech_d;
   logic [7:0] decl_q, decl_d;
   logic ovf_q, ovf_d;
   logic [7:0] rdata_q, rdata_d;
   logic running;
   logic ovf_evt;
   logic [10:0] decimation_ratio_raw, decimation_ratio_eff;

   assign running = ctrl_q[SDMCC_CTRL_EN_BIT];
   assign decimation_ratio_raw = {dech_q, decl_q};
   // Too small a ratio would push the word rate past its ceiling.
   assign decimation_ratio_eff = (decimation_ratio_raw < SDMCC_DECIMATION_RATIO_MIN) ? SDMCC_DECIMATION_RATIO_MIN
                                                   : decimation_ratio_raw;

   always_comb begin
      clkdiv_d = clkdiv_q;
      ctrl_d = ctrl_q;
      offs_d = offs_q;
      dech_d = dech_q;
      decl_d = decl_q;
      rdata_d = rdata_q;
      ovf_d = ovf_q;
      if (sfr_wr_in) begin
         if (hit(sfr_addr_in, SDMCC_ADDR_CLKDIV)) begin
            clkdiv_d = sfr_wdata_in;
         end
         if (hit(sfr_addr_in, SDMCC_ADDR_CTRL)) begin
            ctrl_d = sfr_wdata_in;
         end
         if (hit(sfr_addr_in, SDMCC_ADDR_OFFS)) begin
            offs_d = sfr_wdata_in;
         end
         // Ratio changes mid-conversion would corrupt a word in flight.
         if (hit(sfr_addr_in, SDMCC_ADDR_DECH) && !running) begin
            dech_d = sfr_wdata_in[2:0];
         end
         if (hit(sfr_addr_in, SDMCC_ADDR_DECL) && !running) begin
            decl_d = sfr_wdata_in;
         end
         if (hit(sfr_addr_in, SDMCC_ADDR_STAT) &&
             sfr_wdata_in[SDMCC_STAT_OVF_BIT]) begin
            ovf_d = 1'b0;
         end
      end
      // A lost sample in the same cycle as the clear keeps the flag set.
      if (ovf_evt) begin
         ovf_d = 1'b1;
      end
      if (sfr_rd_in) begin
         case (sfr_addr_in)
            SDMCC_ADDR_CLKDIV: rdata_d = clkdiv_q;
            SDMCC_ADDR_CTRL: rdata_d = ctrl_q;
            SDMCC_ADDR_OFFS: rdata_d = offs_q;
            SDMCC_ADDR_DECH: rdata_d = {5'h00, dech_q};
            SDMCC_ADDR_DECL: rdata_d = decl_q;
            SDMCC_ADDR_STAT: rdata_d = {6'h00, running, ovf_q};
            default: rdata_d = 8'h00;
         endcase
      end
   end

   always_ff @(posedge ref_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         clkdiv_q <= SDMCC_RST_CLKDIV;
         ctrl_q <= SDMCC_RST_CTRL;
         offs_q <= SDMCC_RST_OFFS;
         dech_q <= SDMCC_RST_DECH;
         decl_q <= SDMCC_RST_DECL;
         ovf_q <= 1'b0;
         rdata_q <= 8'h00;
      end else begin
         clkdiv_q <= clkdiv_d;
         ctrl_q <= ctrl_d;
         offs_q <= offs_d;
         dech_q <= dech_d;
         decl_q <= decl_d;
         ovf_q <= ovf_d;
         rdata_q <= rdata_d;
      end
   end

   assign sfr_rdata_out = rdata_q;

   ////////////////////////////////////////////////////////////////////////
   // Front-end selections.

   sdmcc_buf_t buf_sel;
   logic [7:0] gain_d, gain_q;
   logic [2:0] fe_d, fe_q;

   assign buf_sel = sdmcc_buf_t'(ctrl_q[SDMCC_CTRL_BUF_LSB +:
                                        SDMCC_CTRL_BUF_W]);

   always_comb begin
      gain_d = 8'h01 << ctrl_q[SDMCC_CTRL_GAIN_LSB +:
                               SDMCC_CTRL_GAIN_W];
      case (buf_sel)
         SDMCC_BUF_LOW: fe_d = 3'b010;
         SDMCC_BUF_HIGH: fe_d = 3'b100;
         default: fe_d = 3'b001;
      endcase
   end

   always_ff @(posedge ref_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         gain_q <= 8'h01;
         fe_q <= 3'b001;
      end else begin
         gain_q <= gain_d;
         fe_q <= fe_d;
      end
   end

   assign pga_gain_sel_out = gain_q;
   assign buf_high_en_out = fe_q[2];
   assign buf_low_en_out = fe_q[1];
   assign buf_bypass_out = fe_q[0];
   assign ref_ext_sel_out = ctrl_q[SDMCC_CTRL_REFX_BIT];
   assign offset_dac_out = offs_q;

   ////////////////////////////////////////////////////////////////////////
   // Modulator clock, sampling and code stream.

   localparam logic [6:0] OSR_LAST = 7'(SDMCC_OSR - 1);

   logic [7:0] div_cnt_q, div_cnt_d;
   logic mclk_q, mclk_d;
   logic [6:0] osr_cnt_q, osr_cnt_d;
   logic smp_q, smp_d;
   logic bit_q, bit_d;
   logic [10:0] dec_cnt_q, dec_cnt_d;
   logic word_q, word_d;
   logic pop;

   sdmcc_fifo_if #(.WIDTH(1)) fif ();

   always_comb begin
      div_cnt_d = 8'h00;
      mclk_d = 1'b0;
      osr_cnt_d = osr_cnt_q;
      smp_d = 1'b0;
      bit_d = bit_q;
      dec_cnt_d = dec_cnt_q;
      word_d = 1'b0;
      if (running) begin
         // The >= lets a shrunk divisor take effect without a long wrap.
         if (div_cnt_q >= clkdiv_q) begin
            mclk_d = 1'b1;
         end else begin
            div_cnt_d = div_cnt_q + 8'h01;
         end
      end else begin
         osr_cnt_d = 7'h00;
         dec_cnt_d = 11'h000;
      end
      if (running && mclk_q) begin
         if (osr_cnt_q == OSR_LAST) begin
            osr_cnt_d = 7'h00;
            smp_d = 1'b1;
            bit_d = mod_bit_in;
         end else begin
            osr_cnt_d = osr_cnt_q + 7'h01;
         end
      end
      if (running && pop) begin
         if (dec_cnt_q >= decimation_ratio_eff) begin
            dec_cnt_d = 11'h000;
            word_d = 1'b1;
         end else begin
            dec_cnt_d = dec_cnt_q + 11'h001;
         end
      end
   end

   always_ff @(posedge ref_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         div_cnt_q <= 8'h00;
         mclk_q <= 1'b0;
         osr_cnt_q <= 7'h00;
         smp_q <= 1'b0;
         bit_q <= 1'b0;
         dec_cnt_q <= 11'h000;
         word_q <= 1'b0;
      end else begin
         div_cnt_q <= div_cnt_d;
         mclk_q <= mclk_d;
         osr_cnt_q <= osr_cnt_d;
         smp_q <= smp_d;
         bit_q <= bit_d;
         dec_cnt_q <= dec_cnt_d;
         word_q <= word_d;
      end
   end

   // A sample offered while the buffer is full is dropped and flagged.
   assign fif.wr_valid = smp_q;
   assign fif.wr_data = bit_q;
   assign ovf_evt = smp_q && !fif.wr_ready;
   assign fif.rd_ready = code_ready_in;
   assign pop = fif.rd_valid && code_ready_in;

   sdmcc_fifo #(
      .WIDTH(1),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .ref_clk_in(ref_clk_in),
      .rstn_in(rstn_in),
      .f(fif.fifo)
   );

   assign modulator_clock_out = mclk_q;
   assign sample_strobe_out = smp_q;
   assign code_valid_out = fif.rd_valid;
   assign code_bit_out = fif.rd_data;
   assign word_strobe_out = word_q;

endmodule // sdmcc_top

`default_nettype wire

// file: tb/sdmcc_checker.sv
`timescale 1ns/1ps
`default_nettype none
module sdmcc_checker (
   input wire logic ref_clk_in,
   input wire logic rstn_in,
   input wire logic [7:0] sfr_addr_in,
   input wire logic sfr_wr_in,
   input wire logic sfr_rd_in,
   input wire logic [7:0] sfr_wdata_in,
   input wire logic [7:0] sfr_rdata_out,
   input wire logic modulator_clock_out,
   input wire logic sample_strobe_out,
   input wire logic [7:0] pga_gain_sel_out,
   input wire logic buf_high_en_out,
   input wire logic buf_low_en_out,
   input wire logic buf_bypass_out,
   input wire logic ref_ext_sel_out,
   input wire logic [7:0] offset_dac_out,
   input wire logic code_valid_out,
   input wire logic code_bit_out,
   input wire logic code_ready_in
);
   logic [7:0] div_q, gap_q, mcnt_q;
   logic gok_q, sok_q;
   ////////////////////////////////////////////////////////////////////////
   // Any write may retime the divider, so the gap checks restart after it.
   always_ff @(posedge ref_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         div_q <= 8'h00;
         gap_q <= 8'h00;
         mcnt_q <= 8'h00;
         gok_q <= 1'b0;
         sok_q <= 1'b0;
      end else begin
         if (sfr_wr_in && sfr_addr_in == 8'hf7) div_q <= sfr_wdata_in;
         gap_q <= modulator_clock_out ? 8'h00 : gap_q + 8'h01;
         mcnt_q <= (sample_strobe_out ? 8'h00 : mcnt_q) +
                   {7'h00, modulator_clock_out};
         gok_q <= !sfr_wr_in && (modulator_clock_out || gok_q);
         sok_q <= !sfr_wr_in && (sample_strobe_out || sok_q);
      end
   end
   ////////////////////////////////////////////////////////////////////////
   default clocking @(posedge ref_clk_in); endclocking
   default disable iff (!rstn_in);
   sequence ctrl_wr;
      sfr_wr_in && sfr_addr_in == 8'hf8;
   endsequence
   sequence div_rd;
      sfr_rd_in && sfr_addr_in == 8'hf7;
   endsequence
   gain_onehot_a: assert property ($onehot(pga_gain_sel_out))
      else $error("gain select not one-hot");
   // The gain output is registered from the control register, so it lands
   // on the second edge after the write.
   gain_write_a: assert property (ctrl_wr |-> ##2
      pga_gain_sel_out == 8'h01 << ($past(sfr_wdata_in, 2) & 8'h07))
      else $error("gain select does not follow control write");
   buf_onehot_a: assert property (
      $onehot({buf_high_en_out, buf_low_en_out, buf_bypass_out}))
      else $error("buffer selection not exactly one");
   ref_write_a: assert property (ctrl_wr |=>
      ref_ext_sel_out == $past(sfr_wdata_in[4]))
      else $error("reference select does not follow control write");
   offset_write_a: assert property (
      sfr_wr_in && sfr_addr_in == 8'hf9 |=>
      offset_dac_out == $past(sfr_wdata_in))
      else $error("offset output does not follow write");
   div_read_a: assert property (div_rd |=>
      sfr_rdata_out == $past(div_q))
      else $error("divisor read-back wrong");
   unmapped_rd_a: assert property (
      sfr_rd_in && sfr_addr_in == 8'h00 |=> sfr_rdata_out == 8'h00)
      else $error("unmapped read not zero");
   mod_period_a: assert property (
      modulator_clock_out && gok_q |-> gap_q == div_q)
      else $error("modulator pulse spacing wrong");
   sample_count_a: assert property (
      sample_strobe_out && sok_q |-> mcnt_q == 8'h80)
      else $error("sample strobe not every 128 pulses");
   code_push_a: assert property (sample_strobe_out |=> code_valid_out)
      else $error("sample not offered to filter");
   code_hold_a: assert property (
      code_valid_out && !code_ready_in |=>
      code_valid_out && $stable(code_bit_out))
      else $error("code head changed while stalled");
endmodule // sdmcc_checker

bind sdmcc_top sdmcc_checker u_chk (.*);
`default_nettype wire

// file: tb/sdmcc_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
module sdmcc_top_tb;
   logic clk = 1'b0;
   logic rstn, wr, rd, rdy, mclk, sstb, bh, bl, bb, rx, cv, cb, ws;
   logic mbit = 1'b0;
   logic [7:0] addr, wd, rdat, gain, offs;
   int bad_count = 0;
   int cmp_count = 0;
   int pops = 0;
   logic q[$];
   sdmcc_top dut (.ref_clk_in(clk), .rstn_in(rstn), .sfr_addr_in(addr),
      .sfr_wr_in(wr), .sfr_rd_in(rd), .sfr_wdata_in(wd),
      .sfr_rdata_out(rdat), .mod_bit_in(mbit), .modulator_clock_out(mclk),
      .sample_strobe_out(sstb), .pga_gain_sel_out(gain),
      .buf_high_en_out(bh), .buf_low_en_out(bl), .buf_bypass_out(bb),
      .ref_ext_sel_out(rx), .offset_dac_out(offs), .code_valid_out(cv),
      .code_bit_out(cb), .code_ready_in(rdy), .word_strobe_out(ws));
   initial begin
      forever #2.5 clk = ~clk;
   end
   ////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         bad_count++;
         $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic conclude();
      $display("compares=%0d mismatches=%0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   task automatic tick();
      @(posedge clk);
      #1;
   endtask
   task automatic fail_if(input logic c);
      if (c) begin
         bad_count++;
         conclude();
      end
   endtask
   task automatic wreg(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wd <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task automatic rreg(input logic [7:0] a, input logic [7:0] e);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      chk(rdat, e);
   endtask
   ////////////////////////////////////////////////////////////////////////
   // The model drops a sample when eight are pending, as the FIFO must.
   always @(posedge clk) begin
      if (ws === 1'b1) begin
         chk(pops, 20);
         pops = 0;
      end
      // A full buffer refuses a sample even when a pop frees a slot.
      if (sstb === 1'b1) begin
         if (q.size() < 8) q.push_back(mbit);
         mbit <= ~mbit;
      end
      if (cv === 1'b1 && rdy) begin
         chk(cb, q.pop_front());
         pops++;
      end
   end
   ////////////////////////////////////////////////////////////////////////
   task automatic t_reset();
      tick();
      chk({gain, bh, bl, bb}, {8'h01, 3'h1});
      chk({rx, mclk, sstb, cv, ws, offs}, 13'h0000);
      rreg(8'hf7, 8'h00);
      rreg(8'h9b, 8'h07);
      rreg(8'h9a, 8'hff);
      $display("reset test done");
   endtask
   task automatic t_regs();
      wreg(8'hf7, 8'ha5);
      rreg(8'hf7, 8'ha5);
      wreg(8'hf7, 8'h5a);
      rreg(8'hf7, 8'h5a);
      wreg(8'h00, 8'hff);
      rreg(8'h00, 8'h00);
      $display("register test done");
   endtask
   task automatic t_ctrl();
      logic [7:0] d;
      logic [2:0] eb;
      for (int i = 0; i < 8; i++) begin
         d = {1'b0, i[1:0], i[0], 1'b0, i[2:0]};
         wreg(8'hf8, d);
         wreg(8'hf9, 8'h80 ^ i[7:0]);
         #1;
         chk(gain, 8'h01 << i[2:0]);
         eb = (i[1:0] == 2) ? 3'h4 : (i[1:0] == 1) ? 3'h2 : 3'h1;
         chk({bh, bl, bb}, eb);
         chk(rx, i[0]);
         chk(offs, 8'h80 ^ i[7:0]);
      end
      $display("control test done");
   endtask
   task automatic t_clock();
      int n, np, t0, gap;
      np = 0;
      gap = 0;
      wreg(8'hf7, 8'h03);
      wreg(8'hf8, 8'h08);
      for (n = 0; n < 1000 && sstb !== 1'b1; n++) begin
         tick();
         if (mclk === 1'b1) begin
            np++;
            if (np == 1) t0 = n;
            if (np == 2) gap = n - t0;
         end
      end
      fail_if(sstb !== 1'b1);
      chk(np, 128);
      chk(gap, 4);
      // Divisor 0x50 gives the modulator rate nearest the recommended one
      // at this system clock; the first pulse after the change is skipped.
      wreg(8'hf7, 8'h50);
      np = 0;
      gap = 0;
      for (n = 0; n < 400 && np < 3; n++) begin
         tick();
         if (mclk === 1'b1) begin
            np++;
            if (np == 2) t0 = n;
            if (np == 3) gap = n - t0;
         end
      end
      fail_if(np < 3);
      chk(gap, 81);
      wreg(8'hf8, 8'h00);
      $display("clock test done");
   endtask
   task automatic t_stream();
      int n, k;
      k = 0;
      wreg(8'h9b, 8'h00);
      wreg(8'h9a, 8'h00);
      wreg(8'hf7, 8'h00);
      wreg(8'hf8, 8'h08);
      wreg(8'h9a, 8'h55);
      rreg(8'h9a, 8'h00);
      for (n = 0; n < 2000 && k < 9; n++) begin
         tick();
         if (sstb === 1'b1) k++;
      end
      fail_if(k < 9);
      rreg(8'hfa, 8'h03);
      wreg(8'hfa, 8'h01);
      rreg(8'hfa, 8'h02);
      @(posedge clk);
      rdy <= 1'b1;
      for (n = 0; n < 3000 && ws !== 1'b1; n++) tick();
      fail_if(ws !== 1'b1);
      tick();
      wreg(8'hf8, 8'h00);
      $display("stream test done");
   endtask
   ////////////////////////////////////////////////////////////////////////
   initial begin
      rstn = 1'b0;
      wr = 1'b0;
      rd = 1'b0;
      rdy = 1'b0;
      addr = 8'h00;
      wd = 8'h00;
      repeat (16) @(posedge clk);
      rstn <= 1'b1;
      t_reset();
      t_regs();
      t_ctrl();
      t_clock();
      t_stream();
      conclude();
   end
endmodule // sdmcc_top_tb
`default_nettype wire
